// file: irf_regs.vh
// Purpose: Register map and constants of the interrupt request flag block
// Assumes: 32-bit AXI4-Lite, one aligned word per register
// Notes:   Offsets are byte addresses
`ifndef IRF_REGS_VH
`define IRF_REGS_VH

`define IRF_ADDR_W          8
`define IRF_DATA_W          32
`define IRF_NPIN            6
`define IRF_NDMA            4
`define IRF_NEVT            10

// Byte offsets
`define IRF_OFS_PIN_FLAGS   8'h00
`define IRF_OFS_DMA_FLAGS   8'h04
`define IRF_OFS_SENSE       8'h08
`define IRF_OFS_EVT_STATUS  8'h0C
`define IRF_OFS_EVT_CLEAR   8'h10
`define IRF_OFS_EVT_ENABLE  8'h14

// Reset values
`define IRF_RST_PIN_FLAGS   6'h00
`define IRF_RST_DMA_FLAGS   4'h0
`define IRF_RST_SENSE       12'h000
`define IRF_RST_EVT         10'h000

// Sense select codes
`define IRF_SENSE_FALL      2'h0
`define IRF_SENSE_RISE      2'h1
`define IRF_SENSE_LOW       2'h2
`define IRF_SENSE_RSVD      2'h3

// AXI responses
`define IRF_RESP_OKAY       2'h0
`define IRF_RESP_SLVERR     2'h2

`endif

// file: irf_top.v
// Purpose: External pin and DMA interrupt request flags behind AXI4-Lite
// Assumes: DMA requests are synchronous inputs to ref_clk; pins pass a two-flop synchroniser
// Notes:   Single outstanding write and read; answers from flip-flops
`include "irf_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module irf_top (
  input  wire                     ref_clk,
  input  wire                     reset_n,
  input  wire                     ext_int_pin0,
  input  wire                     ext_int_pin1,
  input  wire                     ext_int_pin2,
  input  wire                     ext_int_pin3,
  input  wire                     ext_int_pin4,
  input  wire                     ext_int_pin5,
  input  wire                     dma_ch0_end_request,
  input  wire                     dma_ch1_end_request,
  input  wire                     dma_ch2_end_request,
  input  wire                     dma_ch3_end_request,
  input  wire [`IRF_ADDR_W-1:0]   s_axi_awaddr,
  input  wire [2:0]               s_axi_awprot,
  input  wire                     s_axi_awvalid,
  output reg                      s_axi_awready,
  input  wire [`IRF_DATA_W-1:0]   s_axi_wdata,
  input  wire [3:0]               s_axi_wstrb,
  input  wire                     s_axi_wvalid,
  output reg                      s_axi_wready,
  output reg  [1:0]               s_axi_bresp,
  output reg                      s_axi_bvalid,
  input  wire                     s_axi_bready,
  input  wire [`IRF_ADDR_W-1:0]   s_axi_araddr,
  input  wire [2:0]               s_axi_arprot,
  input  wire                     s_axi_arvalid,
  output reg                      s_axi_arready,
  output reg  [`IRF_DATA_W-1:0]   s_axi_rdata,
  output reg  [1:0]               s_axi_rresp,
  output reg                      s_axi_rvalid,
  input  wire                     s_axi_rready,
  output reg                      irq_q
);

  // Reset release
  reg                     rst_meta_q;
  reg                     rst_sync_q;
  wire                    rst_n;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // Byte-lane mask from write strobes
  function [`IRF_DATA_W-1:0] lane_mask;
    input [3:0] strb;
    begin
      lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  // Register offset decode
  function is_mapped;
    input [`IRF_ADDR_W-1:0] addr;
    begin
      case (addr)
        `IRF_OFS_PIN_FLAGS,
        `IRF_OFS_DMA_FLAGS,
        `IRF_OFS_SENSE,
        `IRF_OFS_EVT_STATUS,
        `IRF_OFS_EVT_CLEAR,
        `IRF_OFS_EVT_ENABLE: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // Pin synchronisers
  wire [`IRF_NPIN-1:0]    pin_raw;
  reg  [`IRF_NPIN-1:0]    pin_meta_q;
  reg  [`IRF_NPIN-1:0]    pin_sync_q;
  reg  [`IRF_NPIN-1:0]    pin_prev_q;

  assign pin_raw = {ext_int_pin5, ext_int_pin4, ext_int_pin3,
                    ext_int_pin2, ext_int_pin1, ext_int_pin0};

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= {`IRF_NPIN{1'b1}};
      pin_sync_q <= {`IRF_NPIN{1'b1}};
      pin_prev_q <= {`IRF_NPIN{1'b1}};
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // Register state
  reg  [`IRF_NPIN-1:0]    pin_flags_q;
  reg  [`IRF_NPIN-1:0]    pin_flags_d;
  reg  [`IRF_NPIN-1:0]    clr_armed_q;
  reg  [`IRF_NPIN-1:0]    clr_armed_d;
  reg  [`IRF_NDMA-1:0]    dma_flags_q;
  reg  [2*`IRF_NPIN-1:0]  sense_q;
  reg  [`IRF_NEVT-1:0]    evt_status_q;
  reg  [`IRF_NEVT-1:0]    evt_enable_q;

  // Write channel state
  reg                     aw_got_q;
  reg                     w_got_q;
  reg  [`IRF_ADDR_W-1:0]  wr_addr_q;
  reg  [`IRF_DATA_W-1:0]  wr_data_q;
  reg  [3:0]              wr_strb_q;
  wire                    aw_fire;
  wire                    w_fire;
  wire                    wr_exec;
  wire [`IRF_DATA_W-1:0]  wr_mask;
  wire [`IRF_DATA_W-1:0]  wr_bits;

  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire  = s_axi_wvalid & s_axi_wready;
  assign wr_exec = aw_got_q & w_got_q & ~s_axi_bvalid;
  assign wr_mask = lane_mask(wr_strb_q);
  assign wr_bits = wr_data_q & wr_mask;

  // Read channel
  wire                    ar_fire;
  wire                    pin_rd;

  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign pin_rd  = ar_fire & (s_axi_araddr == `IRF_OFS_PIN_FLAGS);

  // Pin flag next state
  reg  [1:0]              mode;
  reg                     pin_set;
  reg                     pin_clr;
  integer                 i;

  always @* begin
    pin_flags_d = pin_flags_q;
    clr_armed_d = clr_armed_q;
    mode        = `IRF_SENSE_FALL;
    pin_set     = 1'b0;
    pin_clr     = 1'b0;
    for (i = 0; i < `IRF_NPIN; i = i + 1) begin
      mode    = sense_q[2*i +: 2];
      // Clear only a bit that was read as 1 and now written 0
      pin_clr = wr_exec & (wr_addr_q == `IRF_OFS_PIN_FLAGS) & wr_mask[i]
                & ~wr_data_q[i] & clr_armed_q[i];
      case (mode)
        `IRF_SENSE_FALL: pin_set = pin_prev_q[i] & ~pin_sync_q[i];
        `IRF_SENSE_RISE: pin_set = ~pin_prev_q[i] & pin_sync_q[i];
        `IRF_SENSE_LOW:  pin_set = ~pin_sync_q[i];
        default:         pin_set = 1'b0;
      endcase
      if (mode == `IRF_SENSE_LOW) begin
        pin_flags_d[i] = ~pin_sync_q[i];
      end else begin
        pin_flags_d[i] = pin_set | (pin_flags_q[i] & ~pin_clr);
      end
      if (pin_clr) begin
        clr_armed_d[i] = 1'b0;
      end
      if (pin_rd && pin_flags_q[i]) begin
        clr_armed_d[i] = 1'b1;
      end
    end
  end

  // Events: a flag rising sets its sticky status bit
  wire [`IRF_NDMA-1:0]    dma_in;
  wire [`IRF_NEVT-1:0]    evt_set;
  wire [`IRF_NEVT-1:0]    evt_clr;

  assign dma_in  = {dma_ch3_end_request, dma_ch2_end_request,
                    dma_ch1_end_request, dma_ch0_end_request};
  assign evt_set = {dma_in & ~dma_flags_q, pin_flags_d & ~pin_flags_q};
  assign evt_clr = (wr_exec && wr_addr_q == `IRF_OFS_EVT_CLEAR) ?
                   wr_bits[`IRF_NEVT-1:0] : `IRF_RST_EVT;

  // Flag and control registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_flags_q  <= `IRF_RST_PIN_FLAGS;
      clr_armed_q  <= `IRF_RST_PIN_FLAGS;
      dma_flags_q  <= `IRF_RST_DMA_FLAGS;
      sense_q      <= `IRF_RST_SENSE;
      evt_status_q <= `IRF_RST_EVT;
      evt_enable_q <= `IRF_RST_EVT;
      irq_q        <= 1'b0;
    end else begin
      pin_flags_q  <= pin_flags_d;
      clr_armed_q  <= clr_armed_d;
      dma_flags_q  <= dma_in;
      // Set wins over a same-cycle clear
      evt_status_q <= (evt_status_q & ~evt_clr) | evt_set;
      irq_q        <= |(evt_status_q & evt_enable_q);
      if (wr_exec) begin
        case (wr_addr_q)
          `IRF_OFS_SENSE: begin
            sense_q <= (sense_q & ~wr_mask[2*`IRF_NPIN-1:0])
                       | wr_bits[2*`IRF_NPIN-1:0];
          end
          `IRF_OFS_EVT_ENABLE: begin
            evt_enable_q <= (evt_enable_q & ~wr_mask[`IRF_NEVT-1:0])
                            | wr_bits[`IRF_NEVT-1:0];
          end
          // DMA flags are read-only; writes there are dropped
          default: begin
            evt_enable_q <= evt_enable_q;
          end
        endcase
      end
    end
  end

  // Write address/data capture and response
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      wr_addr_q     <= {`IRF_ADDR_W{1'b0}};
      wr_data_q     <= {`IRF_DATA_W{1'b0}};
      wr_strb_q     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `IRF_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_got_q      <= 1'b1;
        wr_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_got_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (w_fire) begin
        w_got_q      <= 1'b1;
        wr_data_q    <= s_axi_wdata;
        wr_strb_q    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_got_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_exec) begin
        s_axi_bvalid <= 1'b1;
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bresp  <= is_mapped(wr_addr_q) ? `IRF_RESP_OKAY : `IRF_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data mux
  reg  [`IRF_DATA_W-1:0]  rd_word;

  always @* begin
    rd_word = {`IRF_DATA_W{1'b0}};
    case (s_axi_araddr)
      `IRF_OFS_PIN_FLAGS:  rd_word[`IRF_NPIN-1:0] = pin_flags_q;
      `IRF_OFS_DMA_FLAGS:  rd_word[`IRF_NDMA-1:0] = dma_flags_q;
      `IRF_OFS_SENSE:      rd_word[2*`IRF_NPIN-1:0] = sense_q;
      `IRF_OFS_EVT_STATUS: rd_word[`IRF_NEVT-1:0] = evt_status_q;
      `IRF_OFS_EVT_ENABLE: rd_word[`IRF_NEVT-1:0] = evt_enable_q;
      default:             rd_word = {`IRF_DATA_W{1'b0}};
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= {`IRF_DATA_W{1'b0}};
      s_axi_rresp   <= `IRF_RESP_OKAY;
    end else begin
      if (ar_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= is_mapped(s_axi_araddr) ? `IRF_RESP_OKAY : `IRF_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// file: irf_top_assertions.sv
// Purpose: Bus answers and flag read values at the top ports
// Assumes: Aligned word accesses only
// Notes:   Bound onto irf_top
`include "irf_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module irf_top_checker (
  input wire logic                   ref_clk,
  input wire logic                   reset_n,
  input wire logic                   dma_ch0_end_request,
  input wire logic                   dma_ch1_end_request,
  input wire logic                   dma_ch2_end_request,
  input wire logic                   dma_ch3_end_request,
  input wire logic [`IRF_ADDR_W-1:0] s_axi_araddr,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [`IRF_DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]             s_axi_rresp,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic [1:0]             s_axi_bresp,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] ra_q;
  logic [3:0] dma_q;
  logic [3:0] dcap_q;
  wire        ar_hs = s_axi_arvalid && s_axi_arready;
  // Flag register lags the inputs one edge
  always @(posedge ref_clk) begin
    dma_q <= {dma_ch3_end_request, dma_ch2_end_request, dma_ch1_end_request, dma_ch0_end_request};
    if (ar_hs) begin
      ra_q   <= s_axi_araddr;
      dcap_q <= dma_q;
    end
  end
  property p_ar_answer; ar_hs |=> s_axi_rvalid; endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("read answer late");
  property p_ar_block; ar_hs |=> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read address accepted twice");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  property p_pin_rsv;
    s_axi_rvalid && ra_q == `IRF_OFS_PIN_FLAGS |-> s_axi_rdata[31:6] == 26'h0;
  endproperty
  a_pin_rsv: assert property (p_pin_rsv) else $error("pin register upper bits set");
  property p_dma_rd;
    s_axi_rvalid && ra_q == `IRF_OFS_DMA_FLAGS |-> s_axi_rdata == {28'h0, dcap_q};
  endproperty
  a_dma_rd: assert property (p_dma_rd) else $error("dma flags wrong");
  property p_unmapped;
    s_axi_rvalid && ra_q > 8'h14 |->
      s_axi_rresp == `IRF_RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  property p_ok;
    s_axi_rvalid && ra_q <= 8'h14 |-> s_axi_rresp == `IRF_RESP_OKAY;
  endproperty
  a_ok: assert property (p_ok) else $error("mapped read refused");
endmodule
bind irf_top irf_top_checker u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
  .dma_ch0_end_request(dma_ch0_end_request), .dma_ch1_end_request(dma_ch1_end_request),
  .dma_ch2_end_request(dma_ch2_end_request), .dma_ch3_end_request(dma_ch3_end_request),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready));
`default_nettype wire

// file: irf_src_model.sv
// Purpose: External pins and DMA end requests seen by the block
// Assumes: Levels change just after a clock edge
// Notes:   Pins idle high so no false falling edge at start
`timescale 1ns/100ps
`default_nettype none
module irf_src_model (
  input  wire logic       ref_clk,
  input  wire logic [5:0] pin_req,
  input  wire logic [3:0] dma_req,
  output var  logic [5:0] pin_lvl,
  output var  logic [3:0] dma_lvl
);
  initial begin
    pin_lvl = 6'h3F;
    dma_lvl = 4'h0;
  end
  // Requests held as levels until the bench drops them
  always @(posedge ref_clk) begin
    pin_lvl <= pin_req;
    dma_lvl <= dma_req;
  end
endmodule
`default_nettype wire

// file: irq_request_flag_regs_tb.sv
// Purpose: Self-checking bench of the request flag registers
// Assumes: Register bus answers per the hand-over timing
// Notes:   Random pin masks and DMA levels from a fixed seed
`include "irf_regs.vh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end
module irq_request_flag_regs_tb;
  logic        ref_clk = 1'h0;
  logic        reset_n = 1'h0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rd_d;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [5:0]  pin_req = 6'h3F, r, idl;
  logic [3:0]  dma_req = 4'h0, dv;
  logic [1:0]  rsp, md;
  wire  [31:0] rdata;
  wire  [1:0]  bresp, rresp;
  wire         awready, wready, bvalid, arready, rvalid, irq_q;
  wire  [5:0]  pin;
  wire  [3:0]  dma;
  int          mismatches = 0, compares = 0;
  always #2.5 ref_clk = ~ref_clk;
  irf_src_model u_src (.ref_clk(ref_clk), .pin_req(pin_req), .dma_req(dma_req),
    .pin_lvl(pin), .dma_lvl(dma));
  irf_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .ext_int_pin0(pin[0]),
    .ext_int_pin1(pin[1]), .ext_int_pin2(pin[2]), .ext_int_pin3(pin[3]),
    .ext_int_pin4(pin[4]), .ext_int_pin5(pin[5]), .dma_ch0_end_request(dma[0]),
    .dma_ch1_end_request(dma[1]), .dma_ch2_end_request(dma[2]), .dma_ch3_end_request(dma[3]),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_q(irq_q));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    begin
      @(posedge ref_clk);
      awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'($urandom);
      aw = 1'h0; w = 1'h0;
      while (!(aw && w)) begin
        @(posedge ref_clk);
        if (awvalid && awready) begin aw = 1'h1; awvalid <= 1'h0; end
        if (wvalid && wready) begin w = 1'h1; wvalid <= 1'h0; end
      end
      while (!(bvalid && bready)) begin
        @(posedge ref_clk);
        if (!(bvalid && bready)) bready <= 1'h1;
      end
      rsp = bresp;
      bready <= 1'h0;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    begin
      @(posedge ref_clk);
      araddr <= a; arvalid <= 1'h1; rready <= 1'($urandom);
      do @(posedge ref_clk); while (!arready);
      arvalid <= 1'h0;
      while (!(rvalid && rready)) begin
        @(posedge ref_clk);
        if (!(rvalid && rready)) rready <= 1'h1;
      end
      rd_d = rdata; rsp = rresp;
      rready <= 1'h0;
    end
  endtask
  function automatic logic [31:0] exp_pin(input logic [1:0] m, input logic [5:0] v,
                                          input logic back);
    return (m == `IRF_SENSE_LOW && back) ? 32'h0 : {26'h0, v};
  endfunction
  task automatic conclude;
    begin
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin #300us; mismatches++; conclude; end
  initial begin
    rd_d = $urandom(32'h14C49AD6);
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'h1;
    repeat (3) @(posedge ref_clk);
    rd(`IRF_OFS_PIN_FLAGS); `CHK(rd_d, 32'h0)
    rd(`IRF_OFS_DMA_FLAGS); `CHK(rd_d, 32'h0)
    rd(8'h40); `CHK(rsp, `IRF_RESP_SLVERR)
    for (int i = 0; i < 3; i++) begin
      md = 2'(i);
      idl = (md == `IRF_SENSE_RISE) ? 6'h00 : 6'h3F;
      pin_req <= idl; repeat (6) @(posedge ref_clk);
      wr(`IRF_OFS_SENSE, {20'h0, {6{md}}});
      rd(`IRF_OFS_SENSE); `CHK(rd_d, {20'h0, {6{md}}})
      rd(`IRF_OFS_PIN_FLAGS); wr(`IRF_OFS_PIN_FLAGS, 32'h0);
      rd(`IRF_OFS_PIN_FLAGS); `CHK(rd_d, 32'h0)
      r = 6'($urandom) | 6'h01;
      pin_req <= idl ^ r; repeat (6) @(posedge ref_clk);
      rd(`IRF_OFS_PIN_FLAGS); `CHK(rd_d, exp_pin(md, r, 1'h0))
      wr(`IRF_OFS_PIN_FLAGS, 32'h3F);
      rd(`IRF_OFS_PIN_FLAGS); `CHK(rd_d, exp_pin(md, r, 1'h0))
      pin_req <= idl; repeat (6) @(posedge ref_clk);
      rd(`IRF_OFS_PIN_FLAGS); `CHK(rd_d, exp_pin(md, r, 1'h1))
      wr(`IRF_OFS_PIN_FLAGS, {26'h0, r & 6'h3E});
      rd(`IRF_OFS_PIN_FLAGS); `CHK(rd_d, exp_pin(md, r, 1'h1) & 32'h3E)
    end
    // Reserved sense code: no edge or level may set a flag
    wr(`IRF_OFS_SENSE, {20'h0, {6{`IRF_SENSE_RSVD}}});
    pin_req <= 6'h00; repeat (6) @(posedge ref_clk);
    rd(`IRF_OFS_PIN_FLAGS); `CHK(rd_d, 32'h0)
    pin_req <= 6'h3F; repeat (6) @(posedge ref_clk);
    rd(`IRF_OFS_PIN_FLAGS); `CHK(rd_d, 32'h0)
    dv = 4'($urandom);
    dma_req <= dv; repeat (4) @(posedge ref_clk);
    rd(`IRF_OFS_DMA_FLAGS); `CHK(rd_d, {28'h0, dv})
    wr(`IRF_OFS_DMA_FLAGS, {28'h0, ~dv}); `CHK(rsp, `IRF_RESP_OKAY)
    rd(`IRF_OFS_DMA_FLAGS); `CHK(rd_d, {28'h0, dv})
    wr(`IRF_OFS_EVT_ENABLE, 32'h0);
    dma_req <= 4'h0; repeat (4) @(posedge ref_clk);
    wr(`IRF_OFS_EVT_CLEAR, 32'h3FF);
    dma_req <= 4'h1; repeat (4) @(posedge ref_clk);
    rd(`IRF_OFS_EVT_STATUS); `CHK(rd_d, 32'h40)
    `CHK(irq_q, 1'h0)
    wr(`IRF_OFS_EVT_ENABLE, 32'h40); repeat (3) @(posedge ref_clk);
    `CHK(irq_q, 1'h1)
    wr(`IRF_OFS_EVT_CLEAR, 32'h40); repeat (3) @(posedge ref_clk);
    `CHK(irq_q, 1'h0)
    rd(`IRF_OFS_EVT_CLEAR); `CHK(rd_d, 32'h0)
    conclude;
  end
endmodule
`default_nettype wire
